// >>> verilog/shpja_pkg.sv
/*
 Constants for the serial host port and jitter attenuator select block.
 Assumes a 100 MHz system clock and a separate serial clock from the host.
*/
package shpja_pkg;
  localparam int unsigned SHPJA_ADDR_W   = 5;
  localparam int unsigned SHPJA_DATA_W   = 8;
  localparam int unsigned SHPJA_NUM_REGS = 32;
  localparam logic [4:0] SHPJA_CTRL_ADDR  = 5'h01;
  localparam int unsigned SHPJA_IRQ_EN_BIT = 1;
  localparam logic [7:0] SHPJA_REG_RESET  = 8'h00;
  localparam logic [7:0] SHPJA_CTRL_RESET = 8'h02;
  localparam logic [5:0] SHPJA_FIFO_16    = 6'h10;
  localparam logic [5:0] SHPJA_FIFO_32    = 6'h20;
  localparam logic [5:0] SHPJA_FIFO_NONE  = 6'h00;
  localparam logic [3:0] SHPJA_ADDR_END   = 4'h5;
  localparam logic [3:0] SHPJA_FRAME_END  = 4'hD;

  typedef enum logic [1:0]
  {
    SHPJA_ST_CMD  = 2'b00,
    SHPJA_ST_DATA = 2'b01,
    SHPJA_ST_DONE = 2'b10
  } shpja_state_t;
endpackage : shpja_pkg

// >>> verilog/shpja_top.sv
/*
 Serial host port, hardware-mode pin functions and jitter attenuator strap decode.
 Assumes pins arrive asynchronously to sys_clk; the serial clock is the link clock.
*/
`timescale 1ns/1ns

// Overview of operation
// - Serial input sampled on serial clock rise.
// - Read data changes on serial clock fall.
// - Read shifts out addressed command register.
// - Output undriven after data and outside reads.
// - Register reset low restores all defaults.
// - Pending interrupt drives interrupt pin low.
// - Interrupt enable zero suppresses interrupt.
// - Hardware mode gives serial pins static functions.
// - Hardware mode interrupt pin enables mute-on-loss.
// - Select pins choose 16, 32, or disable.
// - Path select high transmit, low receive.
// - Mute forces recovered data low on loss.
module shpja_top
  import shpja_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       serial_clk,
  input  wire logic       host_mode,
  input  wire logic       chip_select_n,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_out_oe,
  input  wire logic       register_reset_n,
  input  wire logic       irq_event,
  input  wire logic       irq_pin_in,
  output logic            irq_pin_out,
  output logic            irq_pin_oe,
  input  wire logic       jitter_select_bit0,
  input  wire logic       jitter_select_bit1,
  input  wire logic       jitter_path_select,
  input  wire logic       signal_loss_condition,
  input  wire logic       raw_positive_data,
  input  wire logic       raw_negative_data,
  output logic            recovered_positive_data,
  output logic            recovered_negative_data,
  output logic            receive_clock_invert,
  output logic            transmit_clock_invert,
  output logic            receiver_power_on,
  input  wire logic       receiver_monitor_select,
  output logic            jitter_enable,
  output logic [5:0]      jitter_fifo_depth,
  output logic            jitter_in_transmit,
  output logic [7:0]      ctrl_register
);

  logic [7:0]  regs_r [SHPJA_NUM_REGS];
  logic [3:0]  bit_cnt_r;
  logic        rd_flag_r;
  logic [4:0]  addr_r;
  logic [7:0]  wdata_r;
  logic        wr_tog_r;
  logic [4:0]  wr_addr_r;
  logic [7:0]  wr_data_r;
  logic [7:0]  rd_shift_r;
  logic        sdo_r;
  logic        sdo_en_r;
  shpja_state_t state_r;
  logic [2:0]  wr_sync_r;
  logic [1:0]  rrst_sync_r;
  logic [1:0]  mode_sync_r;
  logic [1:0]  cs_sync_r;
  logic [1:0]  sdi_sync_r;
  logic [1:0]  sck_sync_r;
  logic [1:0]  mut_sync_r;
  logic [1:0]  los_sync_r;
  logic [1:0]  irq_sync_r;
  logic [1:0]  ja0_sync_r;
  logic [1:0]  ja1_sync_r;
  logic [1:0]  jap_sync_r;
  logic        irq_pend_r;
  logic        link_rst;
  logic [7:0]  ctrl;

  // First frame count of the data phase, where read data is loaded.
  localparam logic [3:0] DATA_FIRST = SHPJA_ADDR_END + 4'h1;

  function automatic logic [5:0] shpja_depth(input logic b0, input logic b1);
    if (b0)
    begin
      shpja_depth = SHPJA_FIFO_NONE;
    end
    else if (b1)
    begin
      shpja_depth = SHPJA_FIFO_32;
    end
    else
    begin
      shpja_depth = SHPJA_FIFO_16;
    end
  endfunction : shpja_depth

  // Default contents of each command register, used by both resets.
  function automatic logic [7:0] shpja_default(input int unsigned idx);
    if (idx == SHPJA_CTRL_ADDR)
    begin
      shpja_default = SHPJA_CTRL_RESET;
    end
    else
    begin
      shpja_default = SHPJA_REG_RESET;
    end
  endfunction : shpja_default

  // The link logic resets while chip select is high, ending each frame.
  assign link_rst = chip_select_n | rst;

  // Frame bit counter and command capture on serial clock rising edges.
  always_ff @(posedge serial_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt_r <= 4'h0;
      rd_flag_r <= 1'b0;
      addr_r    <= 5'h00;
      wdata_r   <= 8'h00;
      state_r   <= SHPJA_ST_CMD;
    end
    else
    begin
      case (state_r)
        SHPJA_ST_CMD:
        begin
          if (bit_cnt_r == 4'h0)
          begin
            rd_flag_r <= serial_data_in;
          end
          else
          begin
            addr_r <= {addr_r[3:0], serial_data_in};
          end
          if (bit_cnt_r == SHPJA_ADDR_END)
          begin
            state_r <= SHPJA_ST_DATA;
          end
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        SHPJA_ST_DATA:
        begin
          wdata_r <= {wdata_r[6:0], serial_data_in};
          if (bit_cnt_r == SHPJA_FRAME_END)
          begin
            state_r <= SHPJA_ST_DONE;
          end
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        SHPJA_ST_DONE:
        begin
          state_r <= SHPJA_ST_DONE;
        end
        default:
        begin
          state_r <= SHPJA_ST_CMD;
        end
      endcase
    end
  end

  // Completed write frames post address and data, then toggle for the crossing.
  // Address and data hold still until the next frame, long after the toggle is seen.
  always_ff @(posedge serial_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_tog_r  <= 1'b0;
      wr_addr_r <= 5'h00;
      wr_data_r <= 8'h00;
    end
    else if (!chip_select_n && state_r == SHPJA_ST_DATA && bit_cnt_r == SHPJA_FRAME_END && !rd_flag_r)
    begin
      wr_addr_r <= addr_r;
      wr_data_r <= {wdata_r[6:0], serial_data_in};
      wr_tog_r  <= ~wr_tog_r;
    end
  end

  // Read data shifts out on falling edges and is released after the last bit.
  // The addressed register only changes after a completed write or on register reset, so it is quiet during a read unless register reset is low.
  always_ff @(negedge serial_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      rd_shift_r <= 8'h00;
      sdo_r      <= 1'b0;
      sdo_en_r   <= 1'b0;
    end
    else if (state_r == SHPJA_ST_DATA && rd_flag_r)
    begin
      if (bit_cnt_r == DATA_FIRST)
      begin
        sdo_r      <= regs_r[addr_r][7];
        rd_shift_r <= {regs_r[addr_r][6:0], 1'b0};
      end
      else
      begin
        sdo_r      <= rd_shift_r[7];
        rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      end
      sdo_en_r <= 1'b1;
    end
    else
    begin
      sdo_en_r <= 1'b0;
    end
  end

  // Pin synchronisers into the system clock domain.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_sync_r   <= 3'h0;
      rrst_sync_r <= 2'h0;
      mode_sync_r <= 2'h0;
      cs_sync_r   <= 2'h3;
      sdi_sync_r  <= 2'h0;
      sck_sync_r  <= 2'h0;
      mut_sync_r  <= 2'h0;
      los_sync_r  <= 2'h0;
      irq_sync_r  <= 2'h0;
      ja0_sync_r  <= 2'h0;
      ja1_sync_r  <= 2'h0;
      jap_sync_r  <= 2'h0;
    end
    else
    begin
      wr_sync_r   <= {wr_sync_r[1:0], wr_tog_r};
      rrst_sync_r <= {rrst_sync_r[0], register_reset_n};
      mode_sync_r <= {mode_sync_r[0], host_mode};
      cs_sync_r   <= {cs_sync_r[0], chip_select_n};
      sdi_sync_r  <= {sdi_sync_r[0], serial_data_in};
      sck_sync_r  <= {sck_sync_r[0], serial_clk};
      mut_sync_r  <= {mut_sync_r[0], irq_pin_in};
      los_sync_r  <= {los_sync_r[0], signal_loss_condition};
      irq_sync_r  <= {irq_sync_r[0], irq_event};
      ja0_sync_r  <= {ja0_sync_r[0], jitter_select_bit0};
      ja1_sync_r  <= {ja1_sync_r[0], jitter_select_bit1};
      jap_sync_r  <= {jap_sync_r[0], jitter_path_select};
    end
  end

  // Command registers, written from the serial port and restored to their defaults by register reset.
  genvar gi;
  generate
    for (gi = 0; gi < SHPJA_NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          regs_r[gi] <= shpja_default(gi);
        end
        else if (!rrst_sync_r[1])
        begin
          regs_r[gi] <= shpja_default(gi);
        end
        else if ((wr_sync_r[2] ^ wr_sync_r[1]) && wr_addr_r == SHPJA_ADDR_W'(gi))
        begin
          regs_r[gi] <= wr_data_r;
        end
      end
    end
  endgenerate

  assign ctrl          = regs_r[SHPJA_CTRL_ADDR];
  assign ctrl_register = ctrl;

  // Interrupt pending level, held while the source is high and enabled in host mode.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_pend_r <= 1'b0;
    end
    else
    begin
      irq_pend_r <= irq_sync_r[1] & ctrl[SHPJA_IRQ_EN_BIT] & mode_sync_r[1];
    end
  end

  // Interrupt pin drives low when pending; released otherwise.
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe  = irq_pend_r;

  // Serial data output pin in host mode; hardware mode leaves it as an input.
  assign serial_data_out    = sdo_r;
  assign serial_data_out_oe = sdo_en_r & ~chip_select_n & host_mode;

  // Hardware mode static functions from the serial pins and the jitter select pins.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      receive_clock_invert  <= 1'b0;
      transmit_clock_invert <= 1'b0;
      receiver_power_on     <= 1'b0;
      jitter_enable         <= 1'b0;
      jitter_fifo_depth     <= SHPJA_FIFO_NONE;
      jitter_in_transmit    <= 1'b0;
    end
    else if (!mode_sync_r[1])
    begin
      receive_clock_invert  <= cs_sync_r[1];
      transmit_clock_invert <= sck_sync_r[1];
      receiver_power_on     <= sdi_sync_r[1];
      jitter_enable         <= ~ja0_sync_r[1];
      jitter_fifo_depth     <= shpja_depth(ja0_sync_r[1], ja1_sync_r[1]);
      jitter_in_transmit    <= jap_sync_r[1];
    end
  end

  // Recovered data muting on signal loss in hardware mode.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      recovered_positive_data <= 1'b0;
      recovered_negative_data <= 1'b0;
    end
    else if (!mode_sync_r[1] && mut_sync_r[1] && los_sync_r[1])
    begin
      recovered_positive_data <= 1'b0;
      recovered_negative_data <= 1'b0;
    end
    else
    begin
      recovered_positive_data <= raw_positive_data;
      recovered_negative_data <= raw_negative_data;
    end
  end

endmodule : shpja_top

// >>> sim/shpja_top_sva.sv
/*
 Concurrent checks on the ports of the serial host port block.
 Assumes one sys_clk domain for sampling and rst as its asynchronous reset.
*/
`timescale 1ns/1ns
module shpja_top_sva
  import shpja_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       serial_clk,
  input wire logic       host_mode,
  input wire logic       chip_select_n,
  input wire logic       serial_data_out,
  input wire logic       serial_data_out_oe,
  input wire logic       register_reset_n,
  input wire logic       irq_event,
  input wire logic       irq_pin_out,
  input wire logic       irq_pin_oe,
  input wire logic       jitter_select_bit0,
  input wire logic       jitter_select_bit1,
  input wire logic       jitter_path_select,
  input wire logic       jitter_enable,
  input wire logic [5:0] jitter_fifo_depth,
  input wire logic       jitter_in_transmit,
  input wire logic [7:0] ctrl_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_oe_in_frame: assert property (serial_data_out_oe |-> !chip_select_n && host_mode)
    else $error("read data driven outside a host frame");
  a_sdo_on_fall: assert property ($changed(serial_data_out) && serial_data_out_oe && $past(serial_data_out_oe)
    |-> !serial_clk) else $error("read data changed while serial clock high");
  a_irq_drive_low: assert property (irq_pin_out == 1'b0)
    else $error("interrupt pin driven high");
  a_irq_masked: assert property (!ctrl_register[SHPJA_IRQ_EN_BIT] [*5] |-> !irq_pin_oe)
    else $error("interrupt raised while disabled");
  a_irq_raise: assert property ((irq_event && ctrl_register[SHPJA_IRQ_EN_BIT] && host_mode) [*6] |-> irq_pin_oe)
    else $error("pending interrupt not signalled");
  a_reg_default: assert property (!register_reset_n [*5] |-> ctrl_register == SHPJA_CTRL_RESET)
    else $error("register reset did not restore control");
  a_fifo_decode: assert property ((!host_mode && $stable({jitter_select_bit1, jitter_select_bit0})) [*6]
    |-> jitter_enable == !jitter_select_bit0 && jitter_fifo_depth == (jitter_select_bit0 ? SHPJA_FIFO_NONE
    : jitter_select_bit1 ? SHPJA_FIFO_32 : SHPJA_FIFO_16)) else $error("jitter select decode wrong");
  a_path_select: assert property ((!host_mode && $stable(jitter_path_select)) [*6]
    |-> jitter_in_transmit == jitter_path_select) else $error("jitter path select wrong");
  a_hw_pin_input: assert property (!host_mode [*4] |-> !irq_pin_oe && !serial_data_out_oe)
    else $error("shared pin driven in hardware mode");

  c_irq: cover property (irq_pin_oe);
  c_read: cover property (serial_data_out_oe);
  c_fifo32: cover property (jitter_fifo_depth == SHPJA_FIFO_32);
  c_hw_mode: cover property (!host_mode && jitter_enable);
endmodule : shpja_top_sva

bind shpja_top shpja_top_sva u_sva (.sys_clk, .rst, .serial_clk, .host_mode, .chip_select_n, .serial_data_out,
  .serial_data_out_oe, .register_reset_n, .irq_event, .irq_pin_out, .irq_pin_oe, .jitter_select_bit0,
  .jitter_select_bit1, .jitter_path_select, .jitter_enable, .jitter_fifo_depth, .jitter_in_transmit, .ctrl_register);

// >>> sim/shpja_host.sv
/*
 Host model that frames serial transfers with chip select and serial clock.
 Assumes the serial clock stands still low outside frames.
*/
`timescale 1ns/1ns
module shpja_host
(
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe
);
  initial
  begin
    serial_clk     = 1'b0;
    chip_select_n  = 1'b1;
    serial_data_in = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [14:0] bits;
    bits = {rd, addr, wdata, 1'b0};
    chip_select_n = 1'b0;
    for (int i = 0; i < 15; i++)
    begin
      serial_data_in = bits[14 - i];
      #16 serial_clk = 1'b1;
      if (i > 5 && i < 14)
        rdata[13 - i] = serial_data_out_oe ? serial_data_out : 1'bx;
      #16 serial_clk = 1'b0;
    end
    #16 chip_select_n = 1'b1;
    serial_data_in = 1'b0;
    #48;
  endtask : xfer
endmodule : shpja_host

// >>> sim/tb_top.sv
/*
 Testbench for the serial host port block: frames, interrupt, straps and mute.
 Assumes the host model and the bound checker beside the design.
*/
`timescale 1ns/1ns
module tb_top
  import shpja_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, host_mode = 1'b1, register_reset_n = 1'b1, irq_event = 1'b0;
  logic irq_pin_in = 1'b0, jitter_select_bit0 = 1'b0, jitter_select_bit1 = 1'b0, jitter_path_select = 1'b0;
  logic signal_loss_condition = 1'b0, raw_positive_data = 1'b0, raw_negative_data = 1'b0;
  logic receiver_monitor_select = 1'b0;
  logic serial_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_out_oe, irq_pin_out, irq_pin_oe;
  logic recovered_positive_data, recovered_negative_data, receive_clock_invert, transmit_clock_invert;
  logic receiver_power_on, jitter_enable, jitter_in_transmit;
  logic [5:0] jitter_fifo_depth;
  logic [7:0] ctrl_register, rd;
  int         checked = 0, n_errors = 0;

  shpja_top dut (.sys_clk, .rst, .serial_clk, .host_mode, .chip_select_n, .serial_data_in, .serial_data_out,
    .serial_data_out_oe, .register_reset_n, .irq_event, .irq_pin_in, .irq_pin_out, .irq_pin_oe,
    .jitter_select_bit0, .jitter_select_bit1, .jitter_path_select, .signal_loss_condition, .raw_positive_data,
    .raw_negative_data, .recovered_positive_data, .recovered_negative_data, .receive_clock_invert,
    .transmit_clock_invert, .receiver_power_on, .receiver_monitor_select, .jitter_enable, .jitter_fifo_depth,
    .jitter_in_transmit, .ctrl_register);
  shpja_host host (.serial_clk, .chip_select_n, .serial_data_in, .serial_data_out, .serial_data_out_oe);

  always #5 sys_clk = ~sys_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic t_frames;
    host.xfer(1'b0, 5'h1F, 8'hC3, rd);
    check(serial_data_out_oe, 1'b0);
    host.xfer(1'b1, 5'h1F, 8'h00, rd);
    check(rd, 8'hC3);
    host.xfer(1'b1, 5'h02, 8'h00, rd);
    check(rd, SHPJA_REG_RESET);
    host.xfer(1'b0, SHPJA_CTRL_ADDR, 8'h5A, rd);
    repeat (6) @(negedge sys_clk);
    check(ctrl_register, 8'h5A);
  endtask : t_frames

  task automatic t_irq;
    irq_event = 1'b1;
    repeat (6) @(negedge sys_clk);
    check({irq_pin_oe, irq_pin_out}, 2'b10);
    host.xfer(1'b0, SHPJA_CTRL_ADDR, 8'h00, rd);
    repeat (6) @(negedge sys_clk);
    check(irq_pin_oe, 1'b0);
    register_reset_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(ctrl_register, SHPJA_CTRL_RESET);
    check(irq_pin_oe, 1'b1);
    register_reset_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    host.xfer(1'b1, 5'h1F, 8'h00, rd);
    check(rd, SHPJA_REG_RESET);
  endtask : t_irq

  task automatic t_hw;
    @(negedge sys_clk);
    host_mode = 1'b0;
    {raw_positive_data, raw_negative_data} = 2'b11;
    for (int i = 0; i < 4; i++)
    begin
      {jitter_select_bit1, jitter_select_bit0} = 2'(i);
      {host.serial_clk, host.chip_select_n} = 2'(i);
      host.serial_data_in = ~i[0];
      jitter_path_select = i[0];
      irq_pin_in = i[0];
      signal_loss_condition = i[1];
      repeat (8) @(negedge sys_clk);
      check(jitter_fifo_depth, i[0] ? SHPJA_FIFO_NONE : i[1] ? SHPJA_FIFO_32 : SHPJA_FIFO_16);
      check(jitter_enable, !i[0]);
      check(jitter_in_transmit, i[0]);
      check({receive_clock_invert, transmit_clock_invert, receiver_power_on}, {i[0], i[1], ~i[0]});
      check({serial_data_out_oe, irq_pin_oe}, 2'b00);
      check({recovered_positive_data, recovered_negative_data}, (i == 3) ? 2'b00 : 2'b11);
    end
    irq_event = 1'b0;
    host_mode = 1'b1;
    {host.serial_clk, host.chip_select_n, host.serial_data_in} = 3'b010;
    repeat (6) @(negedge sys_clk);
  endtask : t_hw

  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    #23 host.serial_clk = 1'b1;
    #16 host.serial_clk = 1'b0;
  end

  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(ctrl_register, SHPJA_CTRL_RESET);
    t_frames;
    @(negedge sys_clk);
    t_irq;
    t_hw;
    test_done;
  end
endmodule : tb_top
